/* inc/gils_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef GILS_MAP_SVH
`define GILS_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define GILS_OFS_INDICATOR_PIN_CONFIG 12'h1BC
`define GILS_OFS_PIN_INT_STATUS_ENABLE 12'h1E8
`define GILS_OFS_SYSTEM_INT_STATUS 12'h1F0
`define GILS_OFS_SYSTEM_INT_ENABLE 12'h1F4
`define GILS_OFS_LOADER_OVERRIDE 12'h1F8
// ==========================================================
// Field positions
`define GILS_PIN_STATUS_LSB 0
`define GILS_PIN_ENABLE_LSB 16
`define GILS_SUMMARY_BIT 12
`define GILS_IND_ENABLE_LSB 0
`define GILS_IND_FUNCTION_LSB 8
`define GILS_LOADER_FUNCTION_VALID_BIT 31
`define GILS_LOADER_ENABLE_VALID_BIT 30
// ==========================================================
// Reset values
`define GILS_RESET_PIN_STATUS 12'h000
`define GILS_RESET_PIN_ENABLE 12'h000
`define GILS_RESET_SYS_ENABLE 1'h0
// ==========================================================
// Timing: least time a pin interrupt level must stand
`define GILS_PIN_HOLD_NS 40
`define GILS_CLOCK_NS 10
`define GILS_PIN_HOLD_CYCLES \
    ((`GILS_PIN_HOLD_NS + `GILS_CLOCK_NS - 1) / `GILS_CLOCK_NS)
`endif

/* inc/gils_pkg.sv */
// Types shared by the pin interrupt and indicator select block
package gils_pkg;
    // ==========================================================
    // Register bus request
    typedef struct packed {
        logic [11:0] address;
        logic [31:0] write_data;
        logic write;
        logic read;
    } gils_bus_t;
    // ==========================================================
    // Indicator source signals per pin
    typedef struct packed {
        logic [7:0] link;
        logic [7:0] activity;
        logic [7:0] speed;
    } gils_led_src_t;
    // Strap sampling states
    typedef enum logic [1:0] {
        gils_strap_wait,
        gils_strap_take,
        gils_strap_done
    } gils_strap_state_t;
endpackage : gils_pkg

/* rtl/gils_level_filter.sv */
// Synchroniser and minimum-width filter for one pin interrupt level
`timescale 1ns/1ns
module gils_level_filter #(
    parameter int unsigned hold_cycles = 4
) (
    input wire logic clock, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic pin, // Raw pin level
    output logic level // Filtered level
);
    typedef struct packed {
        logic [2:0] sync;
        logic [7:0] count;
        logic level;
    } gils_filter_state_t;
    gils_filter_state_t state;
    gils_filter_state_t next_state;
    // ==========================================================
    // Qualify a level only once it has held past the least time
    always_comb begin
        next_state = state;
        next_state.sync = {state.sync[1:0], pin};
        if (state.sync[2] != state.sync[1]) begin
            next_state.count = 8'h00;
        end else if (state.sync[2] == state.level) begin
            next_state.count = 8'h00;
        end else if (state.count >= 8'(hold_cycles - 1)) begin
            next_state.level = state.sync[2];
            next_state.count = 8'h00;
        end else begin
            next_state.count = state.count + 8'h01;
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign level = state.level;
endmodule : gils_level_filter

/* rtl/gils_led_lookup.sv */
// Per-pin indicator function lookup
`timescale 1ns/1ns
module gils_led_lookup #(
    parameter logic [7:0] code0_sel = 8'h00, // Per pin: 0 link, 1 act
    parameter logic [7:0] code1_sel = 8'hFF,
    parameter logic [7:0] code2_sel = 8'h55,
    parameter logic [7:0] code3_sel = 8'hAA,
    parameter logic [7:0] speed_mask = 8'h00 // Pins that show speed
) (
    input wire logic clock, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic [1:0] function_select, // Indicator function code
    input wire gils_pkg::gils_led_src_t source, // Link/activity/speed
    output logic [7:0] indicator // Indicator level per pin
);
    logic [7:0] state;
    logic [7:0] next_state;
    logic [7:0] sel;
    // ==========================================================
    // Configurable table from code to source per pin
    always_comb begin
        case (function_select)
            2'h0: sel = code0_sel;
            2'h1: sel = code1_sel;
            2'h2: sel = code2_sel;
            2'h3: sel = code3_sel;
            default: sel = code0_sel;
        endcase
    end
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            if (speed_mask[i]) begin
                next_state[i] = source.speed[i];
            end else if (sel[i]) begin
                next_state[i] = source.activity[i];
            end else begin
                next_state[i] = source.link[i];
            end
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= 8'h00;
        end else begin
            state <= next_state;
        end
    end
    assign indicator = state;
endmodule : gils_led_lookup

/* rtl/gils_top.sv */
// Pin interrupt status/enable and indicator pin selection
// Overview of operation
// - Writing one to a pin status bit clears it; zero leaves it alone.
// - Enabled pin status bits OR into summary bit 12 of system status.
// - Enable bits 27:16 gate each pin's interrupt and reset to zero.
// - Pin status bits set from the pin condition regardless of enable.
// - The interrupt output needs both pin enable and system enable 12.
// - Status bits 11:0 hold the pin interrupt state and reset to zero.
// - Pin inputs are levels recognised only after standing over 40 ns.
// - Indicator enable bit 0 makes a pin general purpose, 1 indicator.
// - Function bits 9:8 pick indicator roles for enabled pins only.
// - Indicator field defaults come from straps latched after reset.
// - The memory loader may replace latched strap defaults later.
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`include "gils_map.svh"
module gils_top #(
    parameter int unsigned pin_count = 12,
    parameter int unsigned led_count = 8
) (
    input wire logic clock, // System clock, 100 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic [11:0] address, // Register byte address
    input wire logic [31:0] write_data, // Register write data
    input wire logic write, // Write strobe
    input wire logic read, // Read strobe
    output logic [31:0] read_data, // Read data, cycle after strobe
    input wire logic [11:0] pin_interrupt, // Pin interrupt levels
    input wire logic [1:0] indicator_function_strap, // Function strap
    input wire logic [7:0] indicator_enable_strap, // Enable strap
    input wire logic loader_write, // Memory loader override strobe
    input wire logic [1:0] loader_function, // Loader function value
    input wire logic [7:0] loader_enable, // Loader enable value
    input wire gils_pkg::gils_led_src_t led_source, // Indicator sources
    input wire logic [7:0] gpio_out, // General purpose drive per pin
    output logic [7:0] pin_out, // Pin 7:0 output level
    output logic [7:0] indicator_pin_enable, // Pin is an indicator
    output logic interrupt // System interrupt, level, high
);
    typedef struct packed {
        logic [11:0] pin_status;
        logic [11:0] pin_enable;
        logic sys_enable;
        logic [1:0] indicator_function_select;
        logic [7:0] indicator_pin_enable;
        gils_pkg::gils_strap_state_t strap;
        logic [31:0] read_data;
    } gils_top_state_t;
    gils_top_state_t state;
    gils_top_state_t next_state;
    gils_pkg::gils_bus_t bus;
    logic [11:0] pin_level;
    logic [7:0] indicator;
    logic summary;
    logic hit_pin;
    logic hit_led;
    logic hit_sys_status;
    logic hit_sys_enable;
    // ==========================================================
    // Bus request bundle
    assign bus.address = address;
    assign bus.write_data = write_data;
    assign bus.write = write;
    assign bus.read = read;
    assign hit_pin = bus.address == `GILS_OFS_PIN_INT_STATUS_ENABLE;
    assign hit_led = bus.address == `GILS_OFS_INDICATOR_PIN_CONFIG;
    assign hit_sys_status = bus.address == `GILS_OFS_SYSTEM_INT_STATUS;
    assign hit_sys_enable = bus.address == `GILS_OFS_SYSTEM_INT_ENABLE;
    // ==========================================================
    // Pin input filters, one per pin
    for (genvar i = 0; i < pin_count; i++) begin : g_filter
        gils_level_filter #(
            .hold_cycles(`GILS_PIN_HOLD_CYCLES)
        ) u_filter (
            .clock(clock),
            .reset(reset),
            .pin(pin_interrupt[i]),
            .level(pin_level[i])
        );
    end
    // ==========================================================
    // Indicator function lookup
    gils_led_lookup u_lookup (
        .clock(clock),
        .reset(reset),
        .function_select(state.indicator_function_select),
        .source(led_source),
        .indicator(indicator)
    );
    // Summary of enabled pin events
    assign summary = |(state.pin_status & state.pin_enable);
    // ==========================================================
    // Next state: straps, register writes, status capture, reads
    always_comb begin
        next_state = state;
        next_state.read_data = 32'h0000_0000;
        // Strap capture one cycle after reset release
        case (state.strap)
            gils_pkg::gils_strap_wait: begin
                next_state.strap = gils_pkg::gils_strap_take;
            end
            gils_pkg::gils_strap_take: begin
                next_state.indicator_function_select =
                    indicator_function_strap;
                next_state.indicator_pin_enable =
                    indicator_enable_strap;
                next_state.strap = gils_pkg::gils_strap_done;
            end
            gils_pkg::gils_strap_done: begin
                if (loader_write) begin
                    next_state.indicator_function_select =
                        loader_function;
                    next_state.indicator_pin_enable = loader_enable;
                end
            end
            default: begin
                next_state.strap = gils_pkg::gils_strap_wait;
            end
        endcase
        // Register writes
        if (bus.write && hit_pin) begin
            next_state.pin_enable =
                bus.write_data[`GILS_PIN_ENABLE_LSB +: 12];
            next_state.pin_status = state.pin_status &
                ~bus.write_data[`GILS_PIN_STATUS_LSB +: 12];
        end
        if (bus.write && hit_sys_enable) begin
            next_state.sys_enable = bus.write_data[`GILS_SUMMARY_BIT];
        end
        if (bus.write && hit_led) begin
            next_state.indicator_function_select =
                bus.write_data[`GILS_IND_FUNCTION_LSB +: 2];
            next_state.indicator_pin_enable =
                bus.write_data[`GILS_IND_ENABLE_LSB +: 8];
        end
        // Set wins over a clear in the same cycle
        next_state.pin_status = next_state.pin_status | pin_level;
        // Read mux, reserved bits zero
        if (bus.read) begin
            if (hit_pin) begin
                next_state.read_data[`GILS_PIN_STATUS_LSB +: 12] =
                    state.pin_status;
                next_state.read_data[`GILS_PIN_ENABLE_LSB +: 12] =
                    state.pin_enable;
            end else if (hit_led) begin
                next_state.read_data[`GILS_IND_FUNCTION_LSB +: 2] =
                    state.indicator_function_select;
                next_state.read_data[`GILS_IND_ENABLE_LSB +: 8] =
                    state.indicator_pin_enable;
            end else if (hit_sys_status) begin
                next_state.read_data[`GILS_SUMMARY_BIT] = summary;
            end else if (hit_sys_enable) begin
                next_state.read_data[`GILS_SUMMARY_BIT] = state.sys_enable;
            end
        end
    end
    // ==========================================================
    // State register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state.pin_status <= `GILS_RESET_PIN_STATUS;
            state.pin_enable <= `GILS_RESET_PIN_ENABLE;
            state.sys_enable <= `GILS_RESET_SYS_ENABLE;
            state.indicator_function_select <= 2'h0;
            state.indicator_pin_enable <= 8'h00;
            state.strap <= gils_pkg::gils_strap_wait;
            state.read_data <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end
    // ==========================================================
    // Outputs
    assign read_data = state.read_data;
    assign interrupt = summary & state.sys_enable;
    assign indicator_pin_enable = state.indicator_pin_enable;
    for (genvar i = 0; i < led_count; i++) begin : g_pin_mux
        // Function applies only where the pin is an indicator
        assign pin_out[i] = state.indicator_pin_enable[i] ?
            indicator[i] : gpio_out[i];
    end
endmodule : gils_top

/* sim/gils_top_assertions.sv */
// Port-level checks of the pin interrupt and indicator select block
`timescale 1ns/1ns
`include "gils_map.svh"
module gils_top_assertions (
    input wire logic clock, // System clock
    input wire logic reset, // Async reset, high
    input wire logic [11:0] address, // Byte address
    input wire logic [31:0] write_data, // Write data
    input wire logic write, // Write strobe
    input wire logic read, // Read strobe
    input wire logic [31:0] read_data, // Read data
    input wire logic [7:0] indicator_enable_strap, // Enable strap
    input wire logic loader_write, // Loader strobe
    input wire logic [7:0] loader_enable, // Loader enable value
    input wire logic [7:0] gpio_out, // General purpose drive
    input wire logic [7:0] pin_out, // Pin levels
    input wire logic [7:0] indicator_pin_enable, // Indicator pins
    input wire logic interrupt // System interrupt
);
    // ==========================================================
    // Read cycles, ending where the data stands
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence rd_int_s;
        read && address == `GILS_OFS_PIN_INT_STATUS_ENABLE ##1 1;
    endsequence
    sequence rd_ind_s;
        read && address == `GILS_OFS_INDICATOR_PIN_CONFIG ##1 1;
    endsequence
    // ==========================================================
    // Register and pin relations
    int_rsvd_a: assert property (rd_int_s |-> read_data[31:28] == 4'h0
        && read_data[15:12] == 4'h0) else $error("interrupt reserved set");
    ind_rsvd_a: assert property (rd_ind_s |->
        read_data[31:10] == 22'h0) else $error("indicator reserved set");
    ind_read_a: assert property (rd_ind_s |->
        read_data[7:0] == $past(indicator_pin_enable)) else $error("bad read");
    gpio_pass_a: assert property (
        ((pin_out ^ gpio_out) & ~indicator_pin_enable) == 8'h00)
        else $error("general pin not passed");
    ind_write_a: assert property (write &&
        address == `GILS_OFS_INDICATOR_PIN_CONFIG |=>
        indicator_pin_enable == $past(write_data[7:0])) else $error("no write");
    strap_load_a: assert property ($fell(reset) |-> ##[1:3]
        indicator_pin_enable == indicator_enable_strap) else $error("strap");
    loader_load_a: assert property (loader_write |=>
        indicator_pin_enable == $past(loader_enable)) else $error("loader");
    sys_gate_a: assert property (write && !write_data[12] &&
        address == `GILS_OFS_SYSTEM_INT_ENABLE |=> !interrupt)
        else $error("interrupt without system enable");
    pin_gate_a: assert property (write && write_data[27:16] == 12'h000 &&
        address == `GILS_OFS_PIN_INT_STATUS_ENABLE |=> !interrupt)
        else $error("interrupt without pin enable");
endmodule : gils_top_assertions
bind gils_top gils_top_assertions chk_u (.clock(clock), .reset(reset),
    .address(address), .write_data(write_data), .write(write),
    .read(read), .read_data(read_data), .loader_write(loader_write),
    .indicator_enable_strap(indicator_enable_strap), .gpio_out(gpio_out),
    .loader_enable(loader_enable), .pin_out(pin_out),
    .indicator_pin_enable(indicator_pin_enable), .interrupt(interrupt));

/* sim/gils_pin_source.sv */
// External pin interrupt source model
`timescale 1ns/1ns
module gils_pin_source (
    input wire logic clock, // System clock
    input wire logic start, // Begin a level pulse
    input wire logic [11:0] mask, // Pins to raise
    input wire logic [3:0] cycles, // Pulse length in cycles
    output logic [11:0] pin_interrupt = 12'h000 // Pin levels
);
    logic [3:0] left = 4'h0;
    // Hold the level for the asked cycles, then release it
    always @(posedge clock) begin
        if (start) begin
            pin_interrupt <= mask;
            left <= cycles;
        end else if (left > 4'h1) begin
            left <= left - 4'h1;
        end else begin
            pin_interrupt <= 12'h000;
            left <= 4'h0;
        end
    end
endmodule : gils_pin_source

/* sim/tb_top.sv */
// Self-checking bench of the pin interrupt and indicator select block
`timescale 1ns/1ns
`include "gils_map.svh"
module tb_top;
    localparam logic [11:0] o_int = `GILS_OFS_PIN_INT_STATUS_ENABLE;
    localparam logic [11:0] o_ind = `GILS_OFS_INDICATOR_PIN_CONFIG;
    localparam logic [1:0] f_strap = 2'h1;
    localparam logic [7:0] e_strap = 8'hA5;
    logic clock = 1'h0, reset = 1'h1, write = 1'h0, read = 1'h0;
    logic [11:0] address = 12'h000, p_mask = 12'h000, pins;
    logic [31:0] write_data = 32'h0, d, read_data;
    logic p_start = 1'h0, loader_write = 1'h0, interrupt;
    logic [3:0] p_cycles = 4'h0;
    logic [1:0] loader_function = 2'h0;
    logic [7:0] loader_enable = 8'h00, gpio_out = 8'h96, pin_out, ind_en;
    gils_pkg::gils_led_src_t src = '{8'h3C, 8'hA5, 8'h00};
    int n_errors = 0, cmp_count = 0, cycles = 0;
    // ==========================================================
    // Clock, block and pin source
    initial begin
        forever #5 clock = ~clock;
    end
    gils_top dut_u (.clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write(write), .read(read),
        .read_data(read_data), .pin_interrupt(pins),
        .indicator_function_strap(f_strap), .indicator_enable_strap(e_strap),
        .loader_write(loader_write), .loader_function(loader_function),
        .loader_enable(loader_enable), .led_source(src),
        .gpio_out(gpio_out), .pin_out(pin_out),
        .indicator_pin_enable(ind_en), .interrupt(interrupt));
    gils_pin_source src_u (.clock(clock), .start(p_start), .mask(p_mask),
        .cycles(p_cycles), .pin_interrupt(pins));
    // ==========================================================
    // Shared tasks
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, e, input string m);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %0t %s: %h not %h", $time, m, s, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        write <= 1'h1;
        address <= a;
        write_data <= v;
        @(posedge clock);
        write <= 1'h0;
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        read <= 1'h1;
        address <= a;
        @(posedge clock);
        read <= 1'h0;
        @(negedge clock);
        d = read_data;
    endtask : rd
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e, "register read");
    endtask : rchk
    task automatic pulse(input logic [11:0] m, input logic [3:0] n);
        @(posedge clock);
        p_start <= 1'h1;
        p_mask <= m;
        p_cycles <= n;
        @(posedge clock);
        p_start <= 1'h0;
        repeat (14) @(posedge clock);
    endtask : pulse
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rchk(o_int, 32'h0);
        rchk(o_ind, {22'h0, f_strap, e_strap});
        rchk(12'h100, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_status;
        pulse(12'h008, 4'h6);
        rchk(o_int, 32'h8);
        wr(o_int, 32'h0008_0000);
        rchk(o_int, 32'h0008_0008);
        chk({31'h0, interrupt}, 32'h0, "no system enable");
        wr(`GILS_OFS_SYSTEM_INT_ENABLE, 32'h1000);
        chk({31'h0, interrupt}, 32'h1, "interrupt missing");
        rd(`GILS_OFS_SYSTEM_INT_STATUS);
        chk(d & 32'h1000, 32'h1000, "summary bit");
        wr(o_int, 32'h0008_0008);
        rchk(o_int, 32'h0008_0000);
        chk({31'h0, interrupt}, 32'h0, "interrupt stuck");
        pulse(12'h020, 4'h2);
        rchk(o_int, 32'h0008_0000);
        pulse(12'h040, 4'h5);
        rchk(o_int, 32'h0008_0040);
        chk({31'h0, interrupt}, 32'h0, "disabled pin fired");
        wr(`GILS_OFS_SYSTEM_INT_ENABLE, 32'h0);
        $display("status test done");
    endtask : t_status
    task automatic t_led;
        logic [7:0] sel, e;
        wr(o_ind, 32'hFFFF_FFFF);
        rchk(o_ind, 32'h3FF);
        wr(o_int, 32'hFFFF_FFFF);
        rchk(o_int, 32'h0FFF_0000);
        wr(o_int, 32'h0);
        for (int f = 0; f < 4; f++) begin
            wr(o_ind, {22'h0, 2'(f), 8'h0F});
            repeat (3) @(negedge clock);
            sel = 8'(32'hAA55FF00 >> (f * 8));
            e = (src.link & ~sel) | (src.activity & sel);
            chk({24'h0, pin_out}, {24'h0, gpio_out[7:4], e[3:0]}, "pins");
        end
        $display("indicator test done");
    endtask : t_led
    task automatic t_loader;
        @(posedge clock);
        loader_write <= 1'h1;
        loader_function <= 2'h2;
        loader_enable <= 8'h5A;
        @(posedge clock);
        loader_write <= 1'h0;
        rchk(o_ind, 32'h25A);
        chk({24'h0, ind_en}, 32'h5A, "loader enable");
        $display("loader test done");
    endtask : t_loader
    // ==========================================================
    // Timeout and main sequence
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        repeat (4) @(posedge clock);
        t_reset();
        t_status();
        t_led();
        t_loader();
        // Second reset in mid-run: straps latched again
        @(posedge clock);
        reset <= 1'h1;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        repeat (4) @(posedge clock);
        t_reset();
        stop_test();
    end
endmodule : tb_top
